// *** shared/lfcs_defs.vh ***
// Constants for the low-frequency clock source selector block.
// Assumes inclusion by bare name from the design file.
`ifndef LFCS_DEFS_VH
`define LFCS_DEFS_VH
// Register byte offsets on the AXI4-Lite slave
`define LFCS_CTRL_OFS 4'h0
`define LFCS_STAT_OFS 4'h4
`define LFCS_MASK_OFS 4'h8
`define LFCS_SENSE_OFS 4'hc
// Control register fields
`define LFCS_CTRL_KEEP_BIT 0
`define LFCS_CTRL_DRV_LO 1
`define LFCS_CTRL_TRIM_EN_BIT 3
`define LFCS_CTRL_TRIM_LO 8
// Status and mask field
`define LFCS_STAT_CHG_BIT 0
// Sense register fields
`define LFCS_SENSE_SRC_BIT 0
`define LFCS_SENSE_V13_BIT 1
`define LFCS_SENSE_PEND_BIT 2
// Reset values
`define LFCS_DRV_RST 2'h1
`define LFCS_MASK_RST 1'b1
// AXI responses
`define LFCS_RESP_OK 2'h0
`define LFCS_RESP_ERR 2'h2
// Seconds divider nominal length in time-base cycles
`define LFCS_SEC_CYCLES 17'h08000
// Backup oscillator cycles without crystal edges before crystal is judged lost
`define LFCS_LOSS_CYCLES 4
// Crystal edges needed, each within the window, to accept the crystal
`define LFCS_GOOD_EDGES 8
// Ends of the mode-pin code range that raises backup supply to the high level in on modes
`define LFCS_POWERUP_MODE_PINS_HI_A 4'h6
`define LFCS_POWERUP_MODE_PINS_HI_B 4'h9
`endif

// *** hw/lfcs_top.v ***
// Low-frequency time base selector, switch that parks the output low, seconds divider,
// reference clock output control and AXI4-Lite registers.
// Assumes crystal and backup oscillator levels arrive synchronous to mclk,
// which is far faster than either, and nrst is the backup power-on reset.
//
// Behaviour
// RULE1: Backup oscillator substitutes when crystal stops; code judges the stop by backup edges, which it disables on crystal
// RULE2: Backup runs on valid battery, unused with crystal; code disables it while crystal is selected
// RULE3: Control functions use crystal clock when present
// RULE4: Output held stable during source change
// RULE5: Lost crystal falls back to backup; code counts loss in backup edges, which stop while crystal is selected
// RULE6: Source status reads 0 backup, 1 crystal
// RULE7: Source change sets flag; unmasked raises interrupt
// RULE8: Keep-on set keeps processor clock always
// RULE9: Keep-on clear stops processor clock in off
// RULE10: Backup supply enabled from reset, never disabled; code holds it low during nrst, sets it one cycle after release
// RULE11: Mode pins pick 1.3 V or 1.2 V
// RULE12: Two-bit drive select, reset value 01
// RULE13: Processor pulls power key low to wake
// RULE14: External key pull looks like key press
// RULE15: Seconds tick from trimmed 32768-cycle counter
// RULE16: Trim is five-bit two's complement word
// RULE17: Flag latched until one written; irq follows
// RULE18: Sources masked at reset; unmask fires pending
// RULE19: Crystal judged by edges against backup cycles
//
// Implementation choices: the AXI4-Lite interface to the registers and the placing of the registers.
`timescale 1ns/10ps
`include "lfcs_defs.vh"
module lfcs_top #(
    parameter LOSS_CYCLES = `LFCS_LOSS_CYCLES,
    parameter GOOD_EDGES = `LFCS_GOOD_EDGES,
    parameter [16:0] SEC_CYCLES = `LFCS_SEC_CYCLES
) (
    input wire mclk,
    input wire nrst,
    input wire xtal_clk_in,
    input wire backup_osc_in,
    input wire main_battery_supply_ok,
    input wire sys_off,
    input wire [3:0] powerup_mode_pins,
    input wire power_key_input_n,
    output wire backup_osc_enable,
    output reg time_base_clk,
    output reg clock_source_status,
    output wire processor_ref_clock_out,
    output wire processor_ref_clock_en,
    output wire general_ref_clock_out,
    output wire general_ref_clock_en,
    output wire [1:0] ref_clock_drive_sel,
    output reg backup_domain_supply_en,
    output wire backup_supply_1v3,
    output reg seconds_tick,
    output reg power_on_request,
    output wire irq,
    input wire [3:0] s_axi_awaddr,
    input wire s_axi_awvalid,
    output wire s_axi_awready,
    input wire [31:0] s_axi_wdata,
    input wire [3:0] s_axi_wstrb,
    input wire s_axi_wvalid,
    output wire s_axi_wready,
    output reg [1:0] s_axi_bresp,
    output reg s_axi_bvalid,
    input wire s_axi_bready,
    input wire [3:0] s_axi_araddr,
    input wire s_axi_arvalid,
    output wire s_axi_arready,
    output reg [31:0] s_axi_rdata,
    output reg [1:0] s_axi_rresp,
    output reg s_axi_rvalid,
    input wire s_axi_rready
);
    // Switch state machine, one-hot
    localparam ST_RUN = 2'b01;
    localparam ST_HOLD = 2'b10;

    // True when an address is one of the four mapped words
    function mapped;
        input [3:0] addr;
        begin
            mapped = (addr[1:0] == 2'h0);
        end
    endfunction

    reg xtal_d; // Previous crystal level for edge detect
    reg bko_d; // Previous backup oscillator level
    reg [7:0] miss_cnt; // Backup cycles since last crystal edge
    reg [7:0] good_cnt; // Consecutive healthy crystal edges
    reg xtal_ok; // Crystal judged running
    reg [1:0] st; // Switch state
    reg tb_d; // Previous time base level for tick counter
    reg [16:0] sec_cnt; // Seconds divider count
    reg key_d; // Previous power key level
    reg powerup_mode_pins_taken; // Mode pins already captured
    reg [3:0] powerup_mode_pins_lat; // Captured mode pins
    reg keep_on; // Secure clock keep-on control
    reg [1:0] drv_sel; // Drive strength select
    reg trim_en; // Apply trim to divider
    reg [4:0] trim; // Seconds trim word, two's complement
    reg chg_flag; // Sticky clock change flag
    reg chg_mask; // Mask for clock change flag
    reg aw_held; // Write address captured
    reg w_held; // Write data captured
    reg [3:0] aw_addr; // Captured write address
    reg [31:0] w_data; // Captured write data
    reg [3:0] w_strb; // Captured byte strobes
    wire xtal_edge; // Rising edge of crystal
    wire bko_edge; // Rising edge of backup oscillator
    wire want_xtal; // Desired source
    wire src_change; // Selection flips this cycle
    wire [16:0] sec_end; // Trimmed terminal count
    wire wr_go; // Write commits this cycle
    wire wr_clr; // Write one to clear the change flag
    wire [31:0] ctrl_word; // Control register image
    wire [31:0] sense_word; // Read-only sense image

    assign xtal_edge = xtal_clk_in & ~xtal_d;
    assign bko_edge = backup_osc_in & ~bko_d;

    // RULE2: Backup runs gated
    // Running the backup while the crystal is selected would waste coin charge.
    assign backup_osc_enable = main_battery_supply_ok & ~clock_source_status;

    // RULE19: Crystal edge supervision
    // Missing edges are counted in backup cycles; with the backup stopped the
    // crystal is the sole source, so loss is only judged while backup runs.
    always @(posedge mclk) begin
        if (!nrst) begin
            xtal_d <= 1'b0;
            bko_d <= 1'b0;
            miss_cnt <= 8'h00;
            good_cnt <= 8'h00;
            xtal_ok <= 1'b0;
        end else begin
            xtal_d <= xtal_clk_in;
            bko_d <= backup_osc_in;
            if (xtal_edge) begin
                miss_cnt <= 8'h00;
                if (good_cnt == GOOD_EDGES[7:0] - 8'h01)
                    xtal_ok <= 1'b1;
                else
                    good_cnt <= good_cnt + 8'h01;
            end else if (bko_edge) begin
                // RULE5: Fallback on loss
                if (miss_cnt == LOSS_CYCLES[7:0] - 8'h01) begin
                    xtal_ok <= 1'b0;
                    good_cnt <= 8'h00;
                end else begin
                    miss_cnt <= miss_cnt + 8'h01;
                end
            end
        end
    end

    // RULE1: Backup substitutes
    assign want_xtal = xtal_ok;
    assign src_change = (st == ST_HOLD) & ~backup_osc_in & ~xtal_clk_in;

    // Source switch: park the output low at once, wait for both clocks low, then swap sources.
    always @(posedge mclk) begin
        if (!nrst) begin
            st <= ST_RUN;
            clock_source_status <= 1'b0;
            time_base_clk <= 1'b0;
        end else begin
            case (st)
                ST_RUN: begin
                    if (want_xtal != clock_source_status)
                        st <= ST_HOLD;
                    // RULE3: Crystal drives control
                    time_base_clk <= clock_source_status ? xtal_clk_in : backup_osc_in;
                end
                ST_HOLD: begin
                    // RULE4: Hold output low
                    // Holding low at once can cut short a high pulse already begun.
                    time_base_clk <= 1'b0;
                    if (src_change) begin
                        // RULE6: Source status bit
                        clock_source_status <= want_xtal;
                        st <= ST_RUN;
                    end
                end
                default: st <= ST_RUN;
            endcase
        end
    end

    // RULE16: Signed trim word
    assign sec_end = SEC_CYCLES - 17'h00001
        + (trim_en ? {{12{trim[4]}}, trim} : 17'h00000);

    // RULE15: Seconds divider
    // Trim only alters the count length; the output clocks are untouched.
    always @(posedge mclk) begin
        if (!nrst) begin
            tb_d <= 1'b0;
            sec_cnt <= 17'h00000;
            seconds_tick <= 1'b0;
        end else begin
            tb_d <= time_base_clk;
            seconds_tick <= 1'b0;
            if (time_base_clk & ~tb_d) begin
                if (sec_cnt >= sec_end) begin
                    sec_cnt <= 17'h00000;
                    seconds_tick <= 1'b1;
                end else begin
                    sec_cnt <= sec_cnt + 17'h00001;
                end
            end
        end
    end

    // RULE8: Keep-on in all states
    // RULE9: Off stops without keep-on
    assign processor_ref_clock_en = keep_on | ~sys_off;
    assign processor_ref_clock_out = time_base_clk & processor_ref_clock_en;
    assign general_ref_clock_en = ~sys_off;
    assign general_ref_clock_out = time_base_clk & general_ref_clock_en;
    // RULE12: Drive select output
    assign ref_clock_drive_sel = drv_sel;

    // RULE11: Supply level from pins
    assign backup_supply_1v3 = ~sys_off & main_battery_supply_ok
        & (powerup_mode_pins_lat >= `LFCS_POWERUP_MODE_PINS_HI_A) & (powerup_mode_pins_lat <= `LFCS_POWERUP_MODE_PINS_HI_B);

    // Mode pins caught once after reset release; key fall raises turn-on.
    always @(posedge mclk) begin
        if (!nrst) begin
            powerup_mode_pins_taken <= 1'b0;
            powerup_mode_pins_lat <= 4'h0;
            backup_domain_supply_en <= 1'b0;
            key_d <= 1'b1;
            power_on_request <= 1'b0;
        end else begin
            if (!powerup_mode_pins_taken) begin
                powerup_mode_pins_taken <= 1'b1;
                powerup_mode_pins_lat <= powerup_mode_pins;
            end
            // RULE10: Supply always enabled
            backup_domain_supply_en <= 1'b1;
            key_d <= power_key_input_n;
            // RULE13: Wired pull on key
            // RULE14: Same as key press
            power_on_request <= key_d & ~power_key_input_n;
        end
    end

    // AXI4-Lite write: address and data captured in either order.
    assign s_axi_awready = ~aw_held & ~s_axi_bvalid;
    assign s_axi_wready = ~w_held & ~s_axi_bvalid;
    assign wr_go = aw_held & w_held & ~s_axi_bvalid;
    assign wr_clr = wr_go & (aw_addr == `LFCS_STAT_OFS) & w_strb[0]
        & w_data[`LFCS_STAT_CHG_BIT];

    // Register writes and bus handshake
    always @(posedge mclk) begin
        if (!nrst) begin
            aw_held <= 1'b0;
            w_held <= 1'b0;
            aw_addr <= 4'h0;
            w_data <= 32'h00000000;
            w_strb <= 4'h0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= `LFCS_RESP_OK;
            keep_on <= 1'b0;
            drv_sel <= `LFCS_DRV_RST;
            trim_en <= 1'b0;
            trim <= 5'h00;
            // RULE18: Masked at reset
            chg_mask <= `LFCS_MASK_RST;
            chg_flag <= 1'b0;
        end else begin
            if (s_axi_awvalid & s_axi_awready) begin
                aw_held <= 1'b1;
                aw_addr <= s_axi_awaddr;
            end
            if (s_axi_wvalid & s_axi_wready) begin
                w_held <= 1'b1;
                w_data <= s_axi_wdata;
                w_strb <= s_axi_wstrb;
            end
            if (s_axi_bvalid & s_axi_bready)
                s_axi_bvalid <= 1'b0;
            if (wr_go) begin
                aw_held <= 1'b0;
                w_held <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp <= mapped(aw_addr) ? `LFCS_RESP_OK : `LFCS_RESP_ERR;
                if (aw_addr == `LFCS_CTRL_OFS) begin
                    if (w_strb[0]) begin
                        keep_on <= w_data[`LFCS_CTRL_KEEP_BIT];
                        drv_sel <= w_data[`LFCS_CTRL_DRV_LO +: 2];
                        trim_en <= w_data[`LFCS_CTRL_TRIM_EN_BIT];
                    end
                    if (w_strb[1])
                        trim <= w_data[`LFCS_CTRL_TRIM_LO +: 5];
                end
                if ((aw_addr == `LFCS_MASK_OFS) & w_strb[0])
                    chg_mask <= w_data[`LFCS_STAT_CHG_BIT];
            end
            // RULE7: Change sets flag
            // RULE17: Write one clears
            // A change in the clearing cycle wins, so no event is lost.
            if (src_change)
                chg_flag <= 1'b1;
            else if (wr_clr)
                chg_flag <= 1'b0;
        end
    end

    // RULE7: Unmasked flag drives irq
    assign irq = chg_flag & ~chg_mask;

    assign ctrl_word = {19'h00000, trim, 4'h0, trim_en, drv_sel, keep_on};
    assign sense_word = {29'h00000000, st == ST_HOLD, backup_supply_1v3,
        clock_source_status};

    // AXI4-Lite read: one outstanding, answer one cycle after address.
    assign s_axi_arready = ~s_axi_rvalid;
    always @(posedge mclk) begin
        if (!nrst) begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h00000000;
            s_axi_rresp <= `LFCS_RESP_OK;
        end else if (s_axi_arvalid & s_axi_arready) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rresp <= mapped(s_axi_araddr) ? `LFCS_RESP_OK : `LFCS_RESP_ERR;
            case (s_axi_araddr)
                `LFCS_CTRL_OFS: s_axi_rdata <= ctrl_word;
                `LFCS_STAT_OFS: s_axi_rdata <= {31'h00000000, chg_flag};
                `LFCS_MASK_OFS: s_axi_rdata <= {31'h00000000, chg_mask};
                `LFCS_SENSE_OFS: s_axi_rdata <= sense_word;
                default: s_axi_rdata <= 32'h00000000;
            endcase
        end else if (s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
        end
    end
endmodule

// *** dv/lfcs_cpu_model.sv ***
// Processor-side model: wake pull on the power key, reference clock watch.
// Assumes mclk samples far faster than the reference clock.
`timescale 1ns/10ps
module lfcs_cpu_model (
    input wire mclk,
    input wire wake,
    input wire ref_clk,
    output wire key_n,
    output logic [15:0] ref_edges
);
    logic ref_q; // Last seen reference level
    // push-pull wake pull
    // Key line driven high while wake is low, so a released key reads high
    assign key_n = wake ? 1'b0 : 1'b1;
    initial ref_edges = 16'h0000;
    // Count rising reference edges for the keep-on checks
    always @(posedge mclk) begin
        ref_q <= ref_clk;
        if (ref_clk && !ref_q) begin
            ref_edges <= ref_edges + 16'h0001;
        end
    end
endmodule

// *** dv/lfcs_assertions.sv ***
// Port checker for the clock source selector top level.
// Assumes one mclk domain and a synchronous active-low nrst.
`timescale 1ns/10ps
module lfcs_assertions (
    input wire mclk,
    input wire nrst,
    input wire main_battery_supply_ok,
    input wire sys_off,
    input wire power_key_input_n,
    input wire backup_osc_enable,
    input wire time_base_clk,
    input wire clock_source_status,
    input wire processor_ref_clock_out,
    input wire processor_ref_clock_en,
    input wire backup_domain_supply_en,
    input wire backup_supply_1v3,
    input wire seconds_tick,
    input wire power_on_request,
    input wire irq,
    input wire s_axi_bvalid
);
    default clocking @(posedge mclk); endclocking
    default disable iff (!nrst);
    // Output parked low; a short pulse would show as a high here
    sequence held_low;
        !time_base_clk;
    endsequence
    key_press_a: assert property (
        $past(nrst) && $fell(power_key_input_n) |-> ##[1:2] power_on_request
    ) else $error("key fall gave no power-on request");
    supply_hold_a: assert property (
        $past(nrst) |-> backup_domain_supply_en
    ) else $error("backup supply not enabled");
    backup_run_a: assert property (
        backup_osc_enable == (main_battery_supply_ok && !clock_source_status)
    ) else $error("backup oscillator enable wrong");
    switch_hold_a: assert property (
        $changed(clock_source_status) |-> held_low ##1 $stable(clock_source_status)
    ) else $error("time base not parked during switch");
    proc_gate_a: assert property (
        processor_ref_clock_out |-> processor_ref_clock_en && time_base_clk
    ) else $error("processor clock out while disabled");
    proc_on_a: assert property (
        !sys_off |-> processor_ref_clock_en
    ) else $error("processor clock driver off while on");
    irq_reset_a: assert property (
        $rose(nrst) |-> !irq ##1 !irq
    ) else $error("interrupt not masked after reset");
    irq_clear_a: assert property (
        $fell(irq) |-> ##[0:1] s_axi_bvalid
    ) else $error("interrupt dropped without a write");
    supply_lvl_a: assert property (
        backup_supply_1v3 |-> !sys_off && main_battery_supply_ok
    ) else $error("high supply level outside on modes");
    tick_pulse_a: assert property (
        seconds_tick |=> !seconds_tick
    ) else $error("seconds tick longer than one cycle");
endmodule
bind lfcs_top lfcs_assertions i_chk (.*);

// *** dv/tb_low_freq_clock_source_select.sv ***
// Self-checking bench for the clock source selector with a processor model.
// Assumes the design header is on the include path.
`timescale 1ns/10ps
`include "lfcs_defs.vh"
module tb_low_freq_clock_source_select;
    logic mclk, nrst, xtal_clk_in, backup_osc_in, main_battery_supply_ok, sys_off;
    logic wake, xtal_on, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready;
    logic [3:0] powerup_mode_pins, s_axi_awaddr, s_axi_araddr, s_axi_wstrb;
    logic [31:0] s_axi_wdata, rd; // Last read data
    logic [1:0] rs; // Last response code
    logic [15:0] e0;
    wire power_key_input_n, backup_osc_enable, time_base_clk, clock_source_status;
    wire processor_ref_clock_out, processor_ref_clock_en, general_ref_clock_out;
    wire general_ref_clock_en, backup_domain_supply_en, backup_supply_1v3, seconds_tick;
    wire power_on_request, irq, s_axi_awready, s_axi_wready, s_axi_bvalid;
    wire s_axi_arready, s_axi_rvalid;
    wire [1:0] ref_clock_drive_sel, s_axi_bresp, s_axi_rresp;
    wire [31:0] s_axi_rdata;
    wire [15:0] ref_edges;
    int err_count, checked, bc, xc;
    localparam int SEC = 32; // Short seconds divider so ticks fit the run
    // Short counts keep the source switches quick
    lfcs_top #(.LOSS_CYCLES(2), .GOOD_EDGES(2), .SEC_CYCLES(SEC)) i_dut (.*);
    lfcs_cpu_model i_cpu (.mclk(mclk), .wake(wake), .ref_clk(processor_ref_clock_out),
        .key_n(power_key_input_n), .ref_edges(ref_edges));
    initial begin
        mclk = 0;
        forever #10 mclk = ~mclk;
    end
    // Oscillators; a stopped crystal always parks low so a switch back can happen
    always @(posedge mclk) begin
        bc <= (bc == 4) ? 0 : bc + 1;
        xc <= (xc == 3) ? 0 : xc + 1;
        if (bc == 4) backup_osc_in <= ~backup_osc_in;
        if ((xtal_on || xtal_clk_in) && xc == 3) xtal_clk_in <= ~xtal_clk_in;
    end
    task chk(input string nm, input logic [31:0] s, input logic [31:0] e);
        checked++;
        if (s !== e) begin
            err_count++;
            $display("CHECK FAILED %s exp %h seen %h", nm, e, s);
        end
    endtask
    // One AXI4-Lite transfer; w selects write, read data lands in rd
    task automatic axi(input logic w, input logic [3:0] a, input logic [31:0] d);
        logic ta, tw, tr, done;
        done = 0;
        // Let an edge pass so no handshake signal is driven twice in one step
        @(posedge mclk);
        if (w) begin
            s_axi_awaddr <= a;
            s_axi_wdata <= d;
            s_axi_awvalid <= 1;
            s_axi_wvalid <= 1;
            s_axi_bready <= 1;
        end else begin
            s_axi_araddr <= a;
            s_axi_arvalid <= 1;
            s_axi_rready <= 1;
        end
        // Wait as long as it takes; only the watchdog ends a hung transfer
        while (!done) begin
            @(negedge mclk);
            ta = s_axi_awvalid && s_axi_awready;
            tw = s_axi_wvalid && s_axi_wready;
            tr = s_axi_arvalid && s_axi_arready;
            done = (s_axi_bvalid && s_axi_bready) || (s_axi_rvalid && s_axi_rready);
            rd = s_axi_rdata;
            rs = w ? s_axi_bresp : s_axi_rresp;
            @(posedge mclk);
            if (ta) s_axi_awvalid <= 0;
            if (tw) s_axi_wvalid <= 0;
            if (tr) s_axi_arvalid <= 0;
            if (done && w) s_axi_bready <= 0;
            if (done && !w) s_axi_rready <= 0;
        end
    endtask
    // Cycles from one seconds tick to the next, sampled on every rising mclk edge
    task tick_gap(output int n);
        while (seconds_tick !== 1'b1) @(posedge mclk);
        n = 0;
        do begin
            @(posedge mclk);
            n++;
        end while (seconds_tick !== 1'b1);
    endtask
    // Backup time base gives one rising edge every 10 cycles
    task t_tick;
        int n;
        axi(1, `LFCS_CTRL_OFS, 32'h100a);
        tick_gap(n);
        chk("tick_neg", n, (SEC - 16) * 10);
        axi(1, `LFCS_CTRL_OFS, 32'h0f0a);
        tick_gap(n);
        chk("tick_pos", n, (SEC + 15) * 10);
        axi(1, `LFCS_CTRL_OFS, 32'h0f02);
        tick_gap(n);
        chk("tick_nom", n, SEC * 10);
    endtask
    task do_reset;
        nrst <= 0;
        repeat (16) @(posedge mclk);
        nrst <= 1;
        repeat (2) @(posedge mclk);
    endtask
    task wait_src(input logic v);
        for (int n = 0; n < 300 && clock_source_status !== v; n++) @(posedge mclk);
    endtask
    task t_reset;
        chk("drive", ref_clock_drive_sel, 2'h1);
        chk("supply", backup_domain_supply_en, 1);
        axi(0, `LFCS_SENSE_OFS, 0);
        chk("sense", rd[2:0], 3'h0);
        axi(0, `LFCS_MASK_OFS, 0);
        chk("mask", rd[0], 1);
        axi(0, 4'h2, 0);
        chk("unmapped", rs, `LFCS_RESP_ERR);
    endtask
    task t_source;
        xtal_on <= 1;
        wait_src(1);
        chk("xtal", clock_source_status, 1);
        chk("bk_en", backup_osc_enable, 0);
        axi(0, `LFCS_STAT_OFS, 0);
        chk("flag", rd[0], 1);
        chk("masked", irq, 0);
        axi(1, `LFCS_MASK_OFS, 32'h0);
        chk("unmask", irq, 1);
        axi(1, `LFCS_STAT_OFS, 32'h1);
        chk("clear", irq, 0);
        xtal_on <= 0;
        wait_src(0);
        chk("fallback", clock_source_status, 0);
        chk("irq2", irq, 1);
        axi(1, `LFCS_STAT_OFS, 32'h1);
        axi(0, `LFCS_SENSE_OFS, 0);
        chk("src", rd[0], 0);
    endtask
    task t_keep;
        sys_off <= 1;
        axi(1, `LFCS_CTRL_OFS, 32'h4);
        e0 = ref_edges;
        repeat (40) @(posedge mclk);
        chk("drv2", ref_clock_drive_sel, 2'h2);
        chk("mcu_off", processor_ref_clock_en, 0);
        chk("no_edges", ref_edges - e0, 0);
        chk("gen_en", general_ref_clock_en, 0);
        chk("gen_out", general_ref_clock_out, 0);
        axi(1, `LFCS_CTRL_OFS, 32'h5);
        e0 = ref_edges;
        repeat (40) @(posedge mclk);
        chk("mcu_on", processor_ref_clock_en, 1);
        chk("edges", ref_edges > e0, 1);
        sys_off <= 0;
    endtask
    task t_key;
        int got;
        got = 0;
        wake <= 1;
        repeat (6) begin
            @(negedge mclk);
            got += power_on_request;
        end
        chk("wake", got, 1);
        @(posedge mclk);
        wake <= 0;
    endtask
    task t_pins;
        powerup_mode_pins <= 4'h9;
        do_reset;
        chk("v13_on", backup_supply_1v3, 1);
        sys_off <= 1;
        repeat (2) @(posedge mclk);
        chk("v13_off", backup_supply_1v3, 0);
        sys_off <= 0;
    endtask
    task wrap_up;
        $display("checks %0d errors %0d", checked, err_count);
        if (err_count == 0 && checked > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask
    // Watchdog well beyond the expected run length
    initial begin
        repeat (30000) @(posedge mclk);
        err_count++;
        wrap_up;
    end
    initial begin
        {nrst, xtal_clk_in, backup_osc_in, sys_off, wake, xtal_on, bc, xc} = 0;
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 0;
        {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = 0;
        main_battery_supply_ok = 1;
        s_axi_wstrb = 4'hf;
        powerup_mode_pins = 4'h5;
        do_reset;
        t_reset;
        t_source;
        t_keep;
        t_key;
        t_tick;
        t_pins;
        wrap_up;
    end
endmodule
